// [rtl/dhb_pkg.sv]
// Constants for the display host bus interface
// Assumes one 200 MHz clock and all host pins arriving asynchronously
// How it works
// - Eight-bit two-way host data bus carries commands, data and read-back values
// - Serial mode takes bus bit 1 as serial data and bit 0 as clock
// - Enable-strobe mode: read strobe pin is enable, access while high with select low
// - Separate-strobe mode: read strobe low with select low starts a read
// - Enable-strobe mode: write strobe pin high means read, low means write
// - Separate-strobe mode: write strobe low with select low starts a write
// - Data/command select high marks display data, low marks a command byte
// - Reset input held low initialises the whole controller
// - Bus activity is ignored unless chip select is low
// - Enable-strobe mode latches the bus on the enable falling edge
// - Separate-strobe mode latches written bytes on the write strobe rising edge
// - Separate-strobe mode read completes on the read strobe rising edge
package dhb_pkg;
	localparam int  DATA_W      = 8;
	localparam int  FIFO_DEPTH  = 8;
	localparam int  BIT_CNT_W   = 3;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] BIT_ZERO = 3'h0;
	localparam int  SCLK_BIT    = 0;
	localparam int  SERIAL_DATA_INPUT_BIT    = 1;
	localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
	typedef enum logic [2:0]
	{
		MODE_ENABLE   = 3'h1,
		MODE_SEPARATE = 3'h2,
		MODE_SERIAL   = 3'h4
	} dhb_mode_type;
endpackage : dhb_pkg

// [rtl/dhb_fifo.sv]
// Valid/ready FIFO for received bytes
// Assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/1ps
module dhb_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
	logic [AW:0]      cnt_reg, cnt_next;
	logic             push, pop;
	always_comb
	begin
		push      = in_valid && in_ready;
		pop       = out_valid && out_ready;
		in_ready  = cnt_reg != (AW+1)'(DEPTH);
		out_valid = cnt_reg != '0;
		out_data  = mem_reg[rd_reg];
		wr_next   = push ? (wr_reg == AW'(DEPTH-1) ? '0 : wr_reg + 1'b1) : wr_reg;
		rd_next   = pop ? (rd_reg == AW'(DEPTH-1) ? '0 : rd_reg + 1'b1) : rd_reg;
		cnt_next  = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			wr_reg  <= wr_next;
			rd_reg  <= rd_next;
			cnt_reg <= cnt_next;
		end
	end
	always_ff @(posedge mclk)
	begin
		if (push)
			mem_reg[wr_reg] <= in_data;
	end
endmodule : dhb_fifo

// [rtl/dhb_host_port.sv]
// Host bus port: parallel strobes or serial input, bytes out through a FIFO
// Assumes host pins are asynchronous and mode pins are static straps
`timescale 1ns/1ps
module dhb_host_port
	import dhb_pkg::*;
(
	input  wire logic                      mclk,
	input  wire logic                      rst_n,
	input  wire dhb_pkg::dhb_mode_type     bus_mode,
	input  wire logic                      chip_select_n,
	input  wire logic                      read_strobe,
	input  wire logic                      write_strobe,
	input  wire logic                      data_command_select,
	input  wire logic [dhb_pkg::DATA_W-1:0] host_data_bus_in,
	output logic      [dhb_pkg::DATA_W-1:0] host_data_bus_out,
	output logic                           host_data_bus_oe,
	output logic      [dhb_pkg::DATA_W-1:0] rx_byte,
	output logic                           rx_is_data,
	output logic                           rx_valid,
	input  wire logic                      rx_ready,
	input  wire logic [dhb_pkg::DATA_W-1:0] read_value,
	output logic                           read_done,
	output logic                           overrun
);
	import dhb_pkg::*;
	localparam int NS     = DATA_W + 4;
	localparam int PIN_DC = DATA_W;
	localparam int PIN_WR = DATA_W + 1;
	localparam int PIN_RD = DATA_W + 2;
	localparam int PIN_CS = DATA_W + 3;
	// Idle pin image: select high, so no false edge follows reset
	localparam logic [NS-1:0] SYNC_IDLE = {1'b1, {(NS-1){1'b0}}};
	logic [NS-1:0] s1_reg, s2_reg, s3_reg, sin;
	dhb_mode_type  mode_reg, mode_next;
	logic          mode_held_reg;
	logic [BIT_CNT_W-1:0] bit_reg, bit_next;
	logic [DATA_W-1:0]    shf_reg, shf_next, dout_reg, dout_next;
	logic          oe_reg, oe_next, rd_reg, rd_next, push, wr_ev, sclk_rise;
	logic [DATA_W:0] push_data;
	logic          fin_ready, ovr_reg, ovr_next;
	logic          cs_act, en_fall, wr_rise, rd_rise, rd_open;
	assign sin = {chip_select_n, read_strobe, write_strobe, data_command_select, host_data_bus_in};
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_reg <= SYNC_IDLE;
			s2_reg <= SYNC_IDLE;
			s3_reg <= SYNC_IDLE;
		end
		else
		begin
			s1_reg <= sin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	// Synchronised pins: s2 current, s3 previous
	always_comb
	begin
		cs_act    = !s2_reg[PIN_CS];
		en_fall   = s3_reg[PIN_RD] && !s2_reg[PIN_RD] && cs_act;
		wr_rise   = !s3_reg[PIN_WR] && s2_reg[PIN_WR] && cs_act;
		rd_rise   = !s3_reg[PIN_RD] && s2_reg[PIN_RD] && cs_act;
		rd_open   = !s2_reg[PIN_RD] && cs_act;
		sclk_rise = !s3_reg[SCLK_BIT] && s2_reg[SCLK_BIT] && cs_act;
		wr_ev     = 1'b0;
		rd_next   = 1'b0;
		push      = 1'b0;
		push_data = {s2_reg[PIN_DC], s2_reg[DATA_W-1:0]};
		bit_next  = cs_act ? bit_reg : BIT_ZERO;
		shf_next  = shf_reg;
		oe_next   = 1'b0;
		dout_next = read_value;
		mode_next = mode_held_reg ? mode_reg : bus_mode;
		unique case (mode_reg)
			MODE_ENABLE:
			begin
				oe_next = cs_act && s2_reg[PIN_RD] && s2_reg[PIN_WR];
				wr_ev   = en_fall && !s2_reg[PIN_WR];
				rd_next = en_fall && s2_reg[PIN_WR];
			end
			MODE_SEPARATE:
			begin
				oe_next = rd_open;
				wr_ev   = wr_rise;
				rd_next = rd_rise;
			end
			MODE_SERIAL:
			begin
				if (sclk_rise)
				begin
					shf_next = {shf_reg[DATA_W-2:0], s2_reg[SERIAL_DATA_INPUT_BIT]};
					bit_next = bit_reg + 1'b1;
					wr_ev    = bit_reg == BIT_LAST;
					push_data = {s2_reg[PIN_DC], shf_reg[DATA_W-2:0], s2_reg[SERIAL_DATA_INPUT_BIT]};
				end
			end
			default:
			begin
				oe_next = 1'b0;
			end
		endcase
		push     = wr_ev;
		ovr_next = push && !fin_ready;
	end
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_reg      <= MODE_ENABLE;
			mode_held_reg <= 1'b0;
			bit_reg       <= BIT_ZERO;
			shf_reg       <= BYTE_ZERO;
			oe_reg        <= 1'b0;
			dout_reg      <= BYTE_ZERO;
			rd_reg        <= 1'b0;
			ovr_reg       <= 1'b0;
		end
		else
		begin
			mode_reg      <= mode_next;
			mode_held_reg <= 1'b1;
			bit_reg       <= bit_next;
			shf_reg       <= shf_next;
			oe_reg        <= oe_next;
			dout_reg      <= dout_next;
			rd_reg        <= rd_next;
			ovr_reg       <= ovr_next;
		end
	end
	logic [DATA_W:0] fout;
	logic            fvalid;
	dhb_fifo #(.WIDTH(DATA_W+1), .DEPTH(FIFO_DEPTH)) u_fifo (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.in_data   (push_data),
		.in_valid  (push),
		.in_ready  (fin_ready),
		.out_data  (fout),
		.out_valid (fvalid),
		.out_ready (!rx_valid)
	);
	logic [DATA_W:0] rx_reg, rx_next;
	logic            rxv_reg, rxv_next;
	always_comb
	begin
		rxv_next = rxv_reg ? !rx_ready : fvalid;
		rx_next  = (!rxv_reg && fvalid) ? fout : rx_reg;
		if (rxv_reg && rx_ready)
			rxv_next = 1'b0;
	end
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_reg  <= '0;
			rxv_reg <= 1'b0;
		end
		else
		begin
			rx_reg  <= rx_next;
			rxv_reg <= rxv_next;
		end
	end
	assign rx_byte           = rx_reg[DATA_W-1:0];
	assign rx_is_data        = rx_reg[DATA_W];
	assign rx_valid          = rxv_reg;
	assign host_data_bus_out = dout_reg;
	assign host_data_bus_oe  = oe_reg;
	assign read_done         = rd_reg;
	assign overrun           = ovr_reg;
	a_cs_gates_oe: assert property (@(posedge mclk) disable iff (!rst_n)
		s2_reg[PIN_CS] |=> !host_data_bus_oe) else $error("bus driven without select");
	a_sep_wr_push: assert property (@(posedge mclk) disable iff (!rst_n)
		(mode_reg == MODE_SEPARATE && wr_rise) |=> (overrun || fvalid)) else $error("write edge lost");
	a_en_fall_push: assert property (@(posedge mclk) disable iff (!rst_n)
		(mode_reg == MODE_ENABLE && en_fall && !s2_reg[PIN_WR]) |=> (overrun || fvalid))
		else $error("enable write lost");
	a_en_read_done: assert property (@(posedge mclk) disable iff (!rst_n)
		(mode_reg == MODE_ENABLE && en_fall && s2_reg[PIN_WR]) |=> read_done) else $error("enable read lost");
	a_sep_rd_done: assert property (@(posedge mclk) disable iff (!rst_n)
		(mode_reg == MODE_SEPARATE && rd_rise) |=> read_done) else $error("read edge lost");
	a_sep_rd_oe: assert property (@(posedge mclk) disable iff (!rst_n)
		(mode_reg == MODE_SEPARATE && rd_open) |=> host_data_bus_oe) else $error("read not driven");
	a_mode_static: assert property (@(posedge mclk) disable iff (!rst_n)
		$past(mode_held_reg) |-> $stable(mode_reg)) else $error("mode changed");
	a_dc_steers: assert property (@(posedge mclk) disable iff (!rst_n)
		(rx_valid && !rx_ready) |=> rx_valid && $stable({rx_is_data, rx_byte})) else $error("byte kind lost");
	a_serial_byte: assert property (@(posedge mclk) disable iff (!rst_n)
		(mode_reg == MODE_SERIAL && push) |=> bit_reg == BIT_ZERO) else $error("serial count wrong");
	c_enable_write: cover property (@(posedge mclk) disable iff (!rst_n) mode_reg == MODE_ENABLE && push);
	c_sep_read: cover property (@(posedge mclk) disable iff (!rst_n) mode_reg == MODE_SEPARATE && read_done);
	c_serial_byte: cover property (@(posedge mclk) disable iff (!rst_n) mode_reg == MODE_SERIAL && push);
	c_fifo_full: cover property (@(posedge mclk) disable iff (!rst_n) !fin_ready);
endmodule : dhb_host_port

// [verification/dhb_host_model.sv]
// Host processor model driving the display host bus pins
// Assumes the bench resolves the shared bus from the device output enable alone
`timescale 1ns/1ps
module dhb_host_model
	import dhb_pkg::*;
(
	input  wire logic                       mclk,
	input  wire logic [dhb_pkg::DATA_W-1:0] bus,
	output logic                            chip_select_n,
	output logic                            read_strobe,
	output logic                            write_strobe,
	output logic                            data_command_select,
	output logic      [dhb_pkg::DATA_W-1:0] host_drive
);
	initial
	begin
		{chip_select_n, read_strobe, write_strobe, data_command_select} = 4'h8;
		host_drive = 8'h00;
	end
	task automatic hold();
		repeat (6) @(negedge mclk);
	endtask : hold
	// One transfer; cs_n high gives one the device must ignore
	task automatic access(input dhb_mode_type m, input logic rd, input logic dc,
		input logic [DATA_W-1:0] b, input logic cs_n, output logic [DATA_W-1:0] got);
		read_strobe  = (m == MODE_SEPARATE);
		write_strobe = (m == MODE_SEPARATE);
		got          = 8'h00;
		hold();
		chip_select_n       = cs_n;
		data_command_select = dc;
		if (m != MODE_SERIAL)
			host_drive = rd ? ~host_drive : b;
		if (m == MODE_SERIAL)
		begin
			for (int i = 7; i >= 0; i--)
			begin
				host_drive = {6'h00, b[i], 1'b0};
				hold();
				host_drive[SCLK_BIT] = 1'b1;
				hold();
			end
			host_drive = 8'h00;
		end
		else if (m == MODE_ENABLE)
		begin
			write_strobe = rd;
			read_strobe  = 1'b1;
			hold();
			got          = bus;
			read_strobe  = 1'b0;
		end
		else
		begin
			read_strobe  = !rd;
			write_strobe = rd;
			hold();
			got          = bus;
			read_strobe  = 1'b1;
			write_strobe = 1'b1;
		end
		hold();
		chip_select_n = 1'b1;
		if (m != MODE_SERIAL)
			host_drive = ~host_drive;
	endtask : access
endmodule : dhb_host_model

// [verification/tb.sv]
// Self-checking bench for the display host bus port
// Assumes dhb_host_model as the host and a FIFO of FIFO_DEPTH bytes
`timescale 1ns/1ps
module tb;
	import dhb_pkg::*;
	logic              mclk, rst_n, rx_ready, stall, oe, rx_valid, rx_is_data, read_done, overrun;
	logic              chip_select_n, read_strobe, write_strobe, data_command_select;
	logic [DATA_W-1:0] bus, drv, dout, rx_byte, read_value, got, b;
	logic [DATA_W:0]   expq[$];
	dhb_mode_type      mode;
	dhb_mode_type      modes[3] = '{MODE_ENABLE, MODE_SEPARATE, MODE_SERIAL};
	int                error_cnt, n_tests, seed, n_rd, n_ovr, base;
	dhb_host_model host (.mclk, .bus, .chip_select_n, .read_strobe, .write_strobe, .data_command_select,
		.host_drive(drv));
	dhb_host_port dut (.mclk, .rst_n, .bus_mode(mode), .chip_select_n, .read_strobe, .write_strobe,
		.data_command_select, .host_data_bus_in(bus), .host_data_bus_out(dout), .host_data_bus_oe(oe),
		.rx_byte, .rx_is_data, .rx_valid, .rx_ready, .read_value, .read_done, .overrun);
	assign bus = oe ? dout : drv;
	task automatic check(input logic [DATA_W:0] g, input logic [DATA_W:0] e);
		n_tests++;
		if (g !== e)
		begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : check
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	task automatic do_reset(input dhb_mode_type m);
		rst_n = 1'b0;
		mode  = m;
		repeat (4) @(negedge mclk);
		check({5'h00, rx_valid, oe, read_done, overrun}, 9'h000);
		rst_n = 1'b1;
		repeat (6) @(negedge mclk);
	endtask : do_reset
	task automatic put(input logic [DATA_W-1:0] v, input logic d, input logic cs_n);
		if (!cs_n)
			expq.push_back({d, v});
		host.access(mode, 1'b0, d, v, cs_n, got);
	endtask : put
	task automatic wait_empty();
		for (int i = 0; i < 400 && expq.size() != 0; i++)
			@(negedge mclk);
		if (expq.size() != 0)
		begin
			check(9'h000, 9'h1FF);
			end_sim();
		end
	endtask : wait_empty
	always @(posedge mclk)
	begin
		n_rd  <= n_rd + int'(read_done);
		n_ovr <= n_ovr + int'(overrun);
		if (rst_n && rx_valid && rx_ready)
		begin
			if (expq.size() == 0)
				check(9'h000, 9'h1FF);
			else
				check({rx_is_data, rx_byte}, expq.pop_front());
		end
	end
	always @(negedge mclk)
		rx_ready <= !stall && ($random(seed) & 1);
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	initial
	begin
		{error_cnt, n_tests, n_rd, n_ovr} = '0;
		seed       = 32'h54395AAA;
		stall      = 1'b0;
		rx_ready   = 1'b0;
		read_value = 8'h00;
		foreach (modes[k])
		begin
			do_reset(modes[k]);
			for (int i = 0; i < 6; i++)
			begin
				b = (i == 0) ? 8'h80 : (i == 1) ? 8'h01 : 8'($random(seed));
				put(b, 1'($random(seed)), 1'b0);
			end
			put(8'h5A, 1'b1, 1'b1);
			wait_empty();
			for (int c = 0; c < 2 && mode != MODE_SERIAL; c++)
			begin
				read_value = 8'($random(seed));
				base       = n_rd;
				host.access(mode, 1'b1, 1'b1, 8'h00, c[0], got);
				if (c == 0)
					check({1'b0, got}, {1'b0, read_value});
				check(9'(n_rd - base), 9'(1 - c));
			end
			if (mode == MODE_SEPARATE)
			begin
				stall = 1'b1;
				base  = n_ovr;
				// FIFO plus the output register hold FIFO_DEPTH+1 bytes; one more overruns
				for (int i = 0; i <= FIFO_DEPTH + 1; i++)
					put(8'(i), 1'b0, 1'b0);
				void'(expq.pop_back());
				check(9'(n_ovr - base), 9'h001);
				stall = 1'b0;
				wait_empty();
			end
			$display("Mode %0d test done", modes[k]);
		end
		end_sim();
	end
endmodule : tb
